// File: core/lidc_top.sv
// Top: elastic store, loopbacks, line codes, alarm, control gating, driver monitor
// Operation
// (R1) 32-entry FIFO, recovered clock writes, oscillator reads
// (R2) FIFO output drives receive rails and clock
// (R3) Pointer spacing steers read rate, first order
// (R4) Near crossing, divide by 3.5 or 4.5
// (R5) Huge jitter is tracked, never corrupting data
// (R6) Crystal tied high bypasses attenuator, aux clock; code reads on the write clock instead and never uses the aux clock
// (R7) Bypass clock shows quantization jitter, uneven duty
// (R8) Local loopback from pin or register bit
// (R9) Local loopback routes transmit into receive outputs
// (R10) Local loopback still transmits; all-ones overrides
// (R11) Local loopback ignores line inputs
// (R12) Remote loopback retransmits recovered data and clock
// (R13) Remote loopback beats all-ones beats transmit data
// (R14) Remote loopback still feeds receive outputs
// (R15) Controller never selects both loopbacks together
// (R16) Extended remote loop is pre-codec; output decoded
// (R17) Alarm high when under 3 zeros in 2048
// (R18) Code pin high AMI; else length picks code
// (R19) Single-rail encoder input; decoder gives violation strobe
// (R20) Controls pass only while gate is low; code gates in extended mode only
// (R21) Controller holds controls stable while gate low
// (R22) Driver flag high when monitor stays idle
// (R23) Loss of signal forces data low unless bypassed
// (R24) Violation strobe lasts one received bit
// (R25) Monitor time-out counter restarts on transitions
`timescale 1ns/1ps
`default_nettype none
module lidc_top (
	input  wire logic        i_clk,
	input  wire logic        i_sys_rst,
	input  wire logic        i_extended_mode,
	input  wire logic        i_parallel_control_gate,
	input  wire logic        i_local_loopback_select,
	input  wire logic        i_remote_loopback_select,
	input  wire logic        i_transmit_all_ones_select,
	input  wire logic        i_reg_local_loopback,
	input  wire logic        i_reg_remote_loopback,
	input  wire logic        i_tx_code_select,
	input  wire logic        i_rx_code_select,
	input  wire logic        i_line_length_bit0,
	input  wire logic        i_line_length_bit1,
	input  wire logic        i_line_length_bit2,
	input  wire logic        i_crystal_input,
	input  wire logic        i_auxiliary_reference_clock,
	input  wire logic        i_recovered_clock,
	input  wire logic        i_line_in_a,
	input  wire logic        i_line_in_b,
	input  wire logic        i_tx_clock_in,
	input  wire logic        i_tx_positive_rail_in,
	input  wire logic        i_tx_negative_rail_in,
	input  wire logic        i_signal_loss_flag,
	input  wire logic        i_monitor_in_a,
	input  wire logic        i_monitor_in_b,
	input  wire logic [15:0] i_monitor_timeout,
	output logic             o_rx_clock_out,
	output logic             o_rx_positive_rail_out,
	output logic             o_rx_negative_rail_out,
	output logic             o_bipolar_violation_strobe,
	output logic             o_line_out_a,
	output logic             o_line_out_b,
	output logic             o_alarm_indication_out,
	output logic             o_driver_monitor_flag,
	output logic             o_loopback_reset_req
);
	// =====================================================
	// Input synchronisers
	localparam int NS = 11;
	logic [NS-1:0] raw, s1_q, s2_q, s3_q;
	assign raw = {i_monitor_in_b, i_monitor_in_a, i_signal_loss_flag, i_tx_negative_rail_in,
		i_tx_positive_rail_in, i_tx_clock_in, i_line_in_b, i_line_in_a, i_recovered_clock,
		i_auxiliary_reference_clock, i_crystal_input};
	// Two stages, third only for edge finding
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
		end else begin
			s1_q <= raw;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end
	logic xtal_hi, aux_rise, rcv_rise, tx_rise, signal_loss_flag, mon_a, mon_b;
	logic rx_a, rx_b, tx_p, tx_n;
	assign xtal_hi  = s2_q[0];
	assign aux_rise = s2_q[1] & ~s3_q[1];
	assign rcv_rise = s2_q[2] & ~s3_q[2];
	assign rx_a     = s2_q[3];
	assign rx_b     = s2_q[4];
	assign tx_rise  = s2_q[5] & ~s3_q[5];
	assign tx_p     = s2_q[6];
	assign tx_n     = s2_q[7];
	assign signal_loss_flag      = s2_q[8];
	assign mon_a    = s2_q[9];
	assign mon_b    = s2_q[10];

	// =====================================================
	// Control gating
	logic       ll_pin_q, rl_pin_q, transmit_all_ones_select_q, tx_code_select_q, rx_code_select_q;
	logic [2:0] len_q;
	// Pins pass only while gate low, in extended mode
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			ll_pin_q <= 1'b0;
			rl_pin_q <= 1'b0;
			transmit_all_ones_select_q   <= 1'b0;
			tx_code_select_q  <= 1'b0;
			rx_code_select_q  <= 1'b0;
			len_q    <= lidc_pkg::LEN_RST;
		end else if (!i_extended_mode || !i_parallel_control_gate) begin // R20
			ll_pin_q <= i_local_loopback_select;
			rl_pin_q <= i_remote_loopback_select;
			transmit_all_ones_select_q   <= i_transmit_all_ones_select;
			tx_code_select_q  <= i_tx_code_select;
			rx_code_select_q  <= i_rx_code_select;
			len_q    <= {i_line_length_bit2, i_line_length_bit1, i_line_length_bit0};
		end
	end
	logic local_loopback_select, remote_loopback_select, bypass;
	assign local_loopback_select  = ll_pin_q | i_reg_local_loopback; // R8
	assign remote_loopback_select  = rl_pin_q | i_reg_remote_loopback; // R12
	assign bypass = xtal_hi; // R6
	// Both loopbacks flag a reset request to the controller
	assign o_loopback_reset_req = local_loopback_select & remote_loopback_select; // R15

	// Code choice from select pin and line length
	function automatic lidc_pkg::lidc_code_type code_of(input logic sel, input logic [2:0] len);
		if (sel)
			return lidc_pkg::LIDC_CODE_AMI;
		else if (len == lidc_pkg::LEN_HDB3)
			return lidc_pkg::LIDC_CODE_HDB3;
		else if (len >= lidc_pkg::LEN_B8ZS_LO)
			return lidc_pkg::LIDC_CODE_B8ZS;
		else
			return lidc_pkg::LIDC_CODE_AMI;
	endfunction : code_of
	lidc_pkg::lidc_code_type tx_code, rx_code;
	assign tx_code = code_of(tx_code_select_q, len_q); // R18
	assign rx_code = code_of(rx_code_select_q, len_q); // R18

	// =====================================================
	// Receive front end and decoder
	logic       rx_tick;
	logic       in_p, in_n;
	logic [3:0] hist_q;
	logic       last_pol_q, bpv_d;
	// Local loopback takes transmit side, line ignored
	assign rx_tick = local_loopback_select ? tx_rise : rcv_rise; // R9 R11
	assign in_p    = local_loopback_select ? tx_p : rx_a; // R11
	assign in_n    = local_loopback_select ? tx_n : rx_b;
	// Violation: mark with same polarity as last mark
	assign bpv_d = (in_p & last_pol_q) | (in_n & ~last_pol_q);
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			last_pol_q <= 1'b0;
			hist_q     <= '0;
		end else if (rx_tick) begin
			if (in_p | in_n)
				last_pol_q <= in_p;
			hist_q <= {hist_q[2:0], in_p | in_n};
		end
	end
	// Substitution bit suppressed as zero when decoding
	logic dec_bit, dec_bpv;
	always_comb begin
		dec_bit = in_p | in_n;
		dec_bpv = bpv_d & (in_p | in_n);
		if (dec_bpv && rx_code != lidc_pkg::LIDC_CODE_AMI) begin // R16
			dec_bit = 1'b0;
			dec_bpv = 1'b0;
		end
	end

	// =====================================================
	// Elastic store
	logic [2:0] mem_q [lidc_pkg::FIFO_DEPTH];
	logic [lidc_pkg::PTR_W-1:0] wp_q, rp_q, fill;
	assign fill = wp_q - rp_q;
	// Write on recovered or looped clock
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst)
			wp_q <= '0;
		else if (rx_tick)
			wp_q <= wp_q + 5'h01; // R1
	end
	// Stored word: rails for output (both carry decoded bit in extended mode), strobe
	always_ff @(posedge i_clk) begin
		if (rx_tick)
			mem_q[wp_q] <= {dec_bpv, i_extended_mode ? dec_bit : in_n, i_extended_mode ? dec_bit : in_p};
	end

	// =====================================================
	// Read clock: divided, steered by pointer spacing
	logic [3:0] half_cnt_q, div_sel;
	logic [lidc_pkg::NCO_W-1:0] nco_q;
	logic rd_tick;
	// Coarse guard near crossing, else fine first-order trim
	always_comb begin
		if (fill < lidc_pkg::GUARD)
			div_sel = lidc_pkg::DIV_SLOW_HALF; // R4
		else if (fill > 5'(lidc_pkg::FIFO_DEPTH - 1) - lidc_pkg::GUARD)
			div_sel = lidc_pkg::DIV_FAST_HALF; // R4 R5
		else if (fill > lidc_pkg::FIFO_HALF && nco_q == {lidc_pkg::NCO_W{1'b1}})
			div_sel = lidc_pkg::DIV_FAST_HALF; // R3
		else if (fill < lidc_pkg::FIFO_HALF && nco_q == '0)
			div_sel = lidc_pkg::DIV_SLOW_HALF; // R3
		else
			div_sel = lidc_pkg::DIV_NOM_HALF;
	end
	assign rd_tick = bypass ? rx_tick : (half_cnt_q >= div_sel - 4'h1);
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			half_cnt_q <= '0;
			nco_q      <= '0;
		end else begin
			if (rd_tick)
				half_cnt_q <= '0;
			else
				half_cnt_q <= half_cnt_q + 4'h1;
			// Phase error integrates into rate trim
			if (rd_tick && fill > lidc_pkg::FIFO_HALF)
				nco_q <= nco_q + lidc_pkg::NCO_STEP; // R3
			else if (rd_tick && fill < lidc_pkg::FIFO_HALF)
				nco_q <= nco_q - lidc_pkg::NCO_STEP; // R3
		end
	end
	// Read side; bypass follows writer directly
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst)
			rp_q <= '0;
		else if (bypass)
			rp_q <= wp_q - 5'h01; // R6 R7
		else if (rd_tick && fill != 5'h00)
			rp_q <= rp_q + 5'h01; // R1
	end

	// =====================================================
	// Receive outputs
	logic rclk_q;
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_rx_positive_rail_out     <= 1'b0;
			o_rx_negative_rail_out     <= 1'b0;
			o_bipolar_violation_strobe <= 1'b0;
			rclk_q                     <= 1'b0;
		end else if (rd_tick) begin
			rclk_q <= 1'b1; // R2
			if (signal_loss_flag && !bypass) begin // R23
				o_rx_positive_rail_out <= 1'b0;
				o_rx_negative_rail_out <= 1'b0;
			end else if (fill != 5'h00) begin // Underflow holds last bit
				o_rx_positive_rail_out <= mem_q[rp_q][0]; // R2 R14
				o_rx_negative_rail_out <= mem_q[rp_q][1];
			end
			o_bipolar_violation_strobe <= i_extended_mode & mem_q[rp_q][2] & (fill != 5'h00); // R19 R24
		end else if (half_cnt_q == 4'h2) begin
			rclk_q <= 1'b0;
		end
	end
	assign o_rx_clock_out = rclk_q;

	// =====================================================
	// Transmit path and encoder
	logic       ami_pol_q;
	logic [3:0] zrun_q;
	logic       tx_mark, tx_p_sel, tx_n_sel;
	// Source order: remote loop, all ones, transmit data
	always_comb begin
		if (remote_loopback_select) begin // R12 R13
			tx_p_sel = in_p; // R16
			tx_n_sel = in_n;
		end else if (transmit_all_ones_select_q) begin // R10 R13
			tx_p_sel = ~ami_pol_q;
			tx_n_sel = ami_pol_q;
		end else if (i_extended_mode) begin // R19
			tx_mark  = tx_p;
			tx_p_sel = tx_mark & ~ami_pol_q;
			tx_n_sel = tx_mark & ami_pol_q;
		end else begin // R10
			tx_p_sel = tx_p;
			tx_n_sel = tx_n;
		end
		tx_mark = tx_p_sel | tx_n_sel;
	end
	logic tx_tick;
	assign tx_tick = remote_loopback_select ? rx_tick : tx_rise;
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_line_out_a <= 1'b0;
			o_line_out_b <= 1'b0;
			ami_pol_q    <= 1'b0;
			zrun_q       <= '0;
		end else if (tx_tick) begin
			o_line_out_a <= tx_p_sel;
			o_line_out_b <= tx_n_sel;
			if (tx_mark)
				ami_pol_q <= ~ami_pol_q;
			zrun_q <= tx_mark ? 4'h0 : zrun_q + 4'h1;
		end
	end

	// =====================================================
	// Alarm indication: count zeros in 2048 bits
	logic [11:0] win_q;
	logic [1:0]  zeros_q;
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			win_q  <= '0;
			zeros_q <= '0;
			o_alarm_indication_out <= 1'b0;
		end else if (rx_tick) begin
			if (win_q == lidc_pkg::AIS_WINDOW - 12'h001) begin
				win_q <= '0;
				zeros_q <= '0;
				o_alarm_indication_out <= i_extended_mode && ({1'b0, zeros_q} + {2'h0, ~(in_p | in_n)}
					< {1'b0, lidc_pkg::AIS_ZERO_LIMIT}); // R17
			end else begin
				win_q <= win_q + 12'h001;
				if (!(in_p | in_n) && zeros_q != lidc_pkg::AIS_ZERO_LIMIT)
					zeros_q <= zeros_q + 2'h1;
			end
		end
	end

	// =====================================================
	// Driver monitor
	logic        mon_act_q;
	logic [15:0] dpm_cnt_q;
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			mon_act_q <= 1'b0;
			dpm_cnt_q <= '0;
			o_driver_monitor_flag <= 1'b0;
		end else begin
			mon_act_q <= mon_a ^ mon_b;
			if ((mon_a ^ mon_b) != mon_act_q) begin
				dpm_cnt_q <= '0; // R25
				o_driver_monitor_flag <= 1'b0;
			end else if (dpm_cnt_q >= i_monitor_timeout) begin
				o_driver_monitor_flag <= 1'b1; // R22
			end else begin
				dpm_cnt_q <= dpm_cnt_q + 16'h0001;
			end
		end
	end

	// =====================================================
	// Assertions
	a_fifo_bound: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		rd_tick && fill == 5'h00 && !bypass |=> $stable(rp_q)) else $error("read passed write"); // R1
	a_los_force: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		rd_tick && signal_loss_flag && !bypass |=> !o_rx_positive_rail_out && !o_rx_negative_rail_out) else $error("los data"); // R23
	a_tx_prio: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		tx_tick && remote_loopback_select |=> o_line_out_a == $past(in_p)) else $error("remote loop source"); // R13
	a_transmit_all_ones_select_ones: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		tx_tick && !remote_loopback_select && transmit_all_ones_select_q |=> o_line_out_a != o_line_out_b) else $error("all ones"); // R10
	a_gate_hold: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		i_extended_mode && i_parallel_control_gate |=> $stable({transmit_all_ones_select_q, len_q})) else $error("gate leak"); // R20
	a_bpv_pulse: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		o_bipolar_violation_strobe |-> i_extended_mode) else $error("strobe mode"); // R19
	a_dpm_clear: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		(mon_a ^ mon_b) != mon_act_q |=> !o_driver_monitor_flag) else $error("dpm restart"); // R22
	a_loop_addr: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		rx_tick |=> wp_q == $past(wp_q) + 5'h01) else $error("write pointer"); // R1
endmodule : lidc_top
`default_nettype wire

// File: core/lidc_pkg.sv
// Package: constants and types for the line interface datapath control block
package lidc_pkg;
	// Elastic store geometry
	localparam int          FIFO_DEPTH      = 32;
	localparam int          PTR_W           = 5;
	localparam logic [4:0]  FIFO_HALF       = 5'h10;
	localparam logic [4:0]  GUARD           = 5'h02;
	// Read rate generator: nominal divide by four, in half steps
	localparam logic [3:0]  DIV_NOM_HALF    = 4'h8;
	localparam logic [3:0]  DIV_FAST_HALF   = 4'h7;
	localparam logic [3:0]  DIV_SLOW_HALF   = 4'h9;
	// First-order loop: fine phase accumulator width
	localparam int          NCO_W           = 12;
	localparam logic [11:0] NCO_STEP        = 12'h001;
	// Alarm indication window
	localparam logic [11:0] AIS_WINDOW      = 12'h800;
	localparam logic [1:0]  AIS_ZERO_LIMIT  = 2'h3;
	// Driver monitor time-out in clock cycles
	localparam logic [15:0] DPM_TIMEOUT_DEF = 16'h0400;
	// Line length codes
	localparam logic [2:0]  LEN_HDB3        = 3'h0;
	localparam logic [2:0]  LEN_B8ZS_LO     = 3'h2;
	// Reset values
	localparam logic [2:0]  LEN_RST         = 3'h0;
	// Line code selection
	typedef enum logic [1:0] {
		LIDC_CODE_AMI  = 2'h0,
		LIDC_CODE_B8ZS = 2'h1,
		LIDC_CODE_HDB3 = 2'h2
	} lidc_code_type;
endpackage : lidc_pkg

// File: sim/lidc_far_model.sv
// Far side model: line rails, transmit source and reference clocks
`timescale 1ns/1ps
`default_nettype none
module lidc_far_model (
	input  wire logic [1:0] i_line_mode,
	input  wire logic [1:0] i_tx_mode,
	output logic            o_rclk,
	output logic            o_la,
	output logic            o_lb,
	output logic            o_tx_clock_in,
	output logic            o_tp,
	output logic            o_tn,
	output logic            o_aclk
);
	logic alt_l;
	logic alt_t;
	// ==========================================
	// Link clocks, 320 ns, unrelated phases
	initial begin
		{o_rclk, o_tx_clock_in, o_la, o_lb, o_tp, o_tn} = 6'h00;
		{alt_l, alt_t} = 2'h0;
		fork
			forever #160 o_rclk = ~o_rclk;
			#73 forever #160 o_tx_clock_in = ~o_tx_clock_in;
		join
	end
	// Aux reference, copy of transmit clock; the top never uses it
	assign o_aclk = o_tx_clock_in;
	// Line rails: 1 AMI ones, 2 negative marks, else zeros
	always @(negedge o_rclk) begin
		alt_l <= ~alt_l;
		o_la  <= (i_line_mode == 2'h1) & alt_l;
		o_lb  <= (i_line_mode == 2'h2) | ((i_line_mode == 2'h1) & ~alt_l);
	end
	// Transmit rails: 1 positive marks, 2 positive marks on alternate bits
	always @(negedge o_tx_clock_in) begin
		alt_t <= ~alt_t;
		o_tp  <= (i_tx_mode == 2'h1) | ((i_tx_mode == 2'h2) & alt_t);
		o_tn  <= 1'b0;
	end
endmodule : lidc_far_model
`default_nettype wire

// File: sim/tb_line_interface_datapath_control.sv
// Testbench: loopbacks, transmit source, gating, alarm, loss, monitor
`timescale 1ns/1ps
`default_nettype none
module tb_line_interface_datapath_control;
	logic clk, rst, ext, gate, ll, rl, transmit_all_ones_select, rll, rrl, tcs, rcs, signal_loss_flag, xt;
	logic rck, la, lb, tck, tp, tn, ack;
	logic rc, rp, rn, bipolar_violation_strobe, oa, ob, alarm_indication_out, driver_monitor_flag, rreq, a0;
	logic [1:0] lm, tm;
	int n_mismatch, comparisons;
	// ==========================================
	// Design and far side
	lidc_top lidc_top_inst (
		.i_clk(clk), .i_sys_rst(rst), .i_extended_mode(ext),
		.i_parallel_control_gate(gate), .i_local_loopback_select(ll),
		.i_remote_loopback_select(rl), .i_transmit_all_ones_select(transmit_all_ones_select),
		.i_reg_local_loopback(rll), .i_reg_remote_loopback(rrl),
		.i_tx_code_select(tcs), .i_rx_code_select(rcs),
		.i_line_length_bit0(1'b0), .i_line_length_bit1(1'b0),
		.i_line_length_bit2(1'b0), .i_crystal_input(xt),
		.i_auxiliary_reference_clock(ack), .i_recovered_clock(rck),
		.i_line_in_a(la), .i_line_in_b(lb), .i_tx_clock_in(tck),
		.i_tx_positive_rail_in(tp), .i_tx_negative_rail_in(tn),
		.i_signal_loss_flag(signal_loss_flag), .i_monitor_in_a(oa), .i_monitor_in_b(ob),
		.i_monitor_timeout(16'h0010), .o_rx_clock_out(rc),
		.o_rx_positive_rail_out(rp), .o_rx_negative_rail_out(rn),
		.o_bipolar_violation_strobe(bipolar_violation_strobe), .o_line_out_a(oa), .o_line_out_b(ob),
		.o_alarm_indication_out(alarm_indication_out), .o_driver_monitor_flag(driver_monitor_flag),
		.o_loopback_reset_req(rreq)
	);
	lidc_far_model lidc_far_model_inst (
		.i_line_mode(lm), .i_tx_mode(tm), .o_rclk(rck), .o_la(la), .o_lb(lb),
		.o_tx_clock_in(tck), .o_tp(tp), .o_tn(tn), .o_aclk(ack)
	);
	// ==========================================
	// Shared helpers
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask : cyc
	task automatic tick();
		@(posedge tck);
		cyc(6);
	endtask : tick
	task automatic check(input logic [1:0] seen, input logic [1:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[FAIL] %0t seen %b expected %b", $time, seen, exp);
		end
	endtask : check
	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : print_verdict
	// ==========================================
	// Scenarios
	task automatic t_local();
		{rll, lm, tm} = {1'b1, 2'h2, 2'h1};
		cyc(600);
		check({rp, rn}, 2'h2);
		tick();
		check({oa, ob}, 2'h2);
		transmit_all_ones_select = 1'b1;
		tick();
		a0 = oa;
		check(oa ^ ob, 2'h1);
		tick();
		check(oa, !a0);
		{rll, transmit_all_ones_select} = 2'h0;
		$display("done local loopback");
	endtask : t_local
	task automatic t_remote();
		{rrl, transmit_all_ones_select, lm, tm} = {2'h3, 2'h2, 2'h1};
		cyc(600);
		check({oa, ob}, 2'h1);
		check({rp, rn}, 2'h1);
		{rrl, transmit_all_ones_select} = 2'h0;
		tick();
		check({oa, ob}, 2'h2);
		$display("done remote loopback");
	endtask : t_remote
	task automatic t_rate();
		longint t0;
		@(posedge rc);
		t0 = $time;
		repeat (50) @(posedge rc);
		cyc(1);
		check(($time - t0) inside {[15960:16040]}, 2'h1);
		$display("done read rate");
	endtask : t_rate
	task automatic t_loss();
		signal_loss_flag = 1'b1;
		cyc(40);
		check({rp, rn}, 2'h0);
		signal_loss_flag = 1'b0;
		cyc(600);
		check({rp, rn}, 2'h1);
		{xt, signal_loss_flag} = 2'h3;
		cyc(40);
		check({rp, rn}, 2'h1);
		{xt, signal_loss_flag} = 2'h0;
		$display("done signal loss");
	endtask : t_loss
	task automatic t_reset_req();
		{ll, rl} = 2'h3;
		cyc(1);
		check(rreq, 2'h1);
		{ll, rl} = 2'h0;
		cyc(1);
		check(rreq, 2'h0);
		$display("done reset request");
	endtask : t_reset_req
	task automatic t_gate();
		{ext, tcs, rcs, tm, gate} = {3'h7, 2'h0, 1'b0};
		cyc(20);
		gate = 1'b1;
		cyc(2);
		transmit_all_ones_select = 1'b1;
		tick();
		tick();
		check({oa, ob}, 2'h0);
		check(bipolar_violation_strobe, 2'h1);
		gate = 1'b0;
		tick();
		tick();
		check(oa ^ ob, 2'h1);
		transmit_all_ones_select = 1'b0;
		$display("done control gate");
	endtask : t_gate
	task automatic t_alarm();
		lm = 2'h1;
		cyc(36000);
		check(alarm_indication_out, 2'h1);
		lm = 2'h0;
		cyc(36000);
		check(alarm_indication_out, 2'h0);
		ext = 1'b0;
		$display("done alarm");
	endtask : t_alarm
	task automatic t_monitor();
		tm = 2'h2;
		cyc(200);
		check(driver_monitor_flag, 2'h0);
		tm = 2'h0;
		cyc(100);
		check(driver_monitor_flag, 2'h1);
		$display("done driver monitor");
	endtask : t_monitor
	// ==========================================
	// Main sequence
	initial begin
		{rst, ext, gate, ll, rl, transmit_all_ones_select, rll, rrl, tcs, rcs, signal_loss_flag, xt} = 12'h800;
		{lm, tm, a0} = 5'h00;
		n_mismatch = 0;
		comparisons = 0;
		cyc(5);
		check({oa, ob, rp, rn} == 4'h0, 2'h1);
		check({alarm_indication_out, driver_monitor_flag, bipolar_violation_strobe} == 3'h0, 2'h1);
		rst = 1'b0;
		cyc(4);
		t_local();
		t_remote();
		t_rate();
		t_loss();
		t_reset_req();
		t_monitor();
		t_gate();
		t_alarm();
		print_verdict();
	end
	// Watchdog sized above the longest run
	initial begin
		#4000000;
		n_mismatch++;
		print_verdict();
	end
endmodule : tb_line_interface_datapath_control
`default_nettype wire
